// File: hdl/hdrp_device.sv
// Device end: direct register access port seen by the host
`timescale 1ns/1ps
module hdrp_device
   import hdrp_pkg::*;
#(
   parameter int unsigned VEC_W = 8
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Host pins
   hdrp_if.device BUS,
   // Straps
   input wire logic MODE_MUX,
   input wire logic BUS_8BIT,
   // Register side
   output logic [2:0] REG_ADDR,
   output logic REG_BYTE_HIGH_N,
   output logic [15:0] REG_WDATA,
   output logic REG_WE,
   output logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic REG_BUSY,
   input wire logic [VEC_W-1:0] IRQ_VECTOR,
   output logic IACK_DONE
);

   ////////////////////////////////////////////////////////////////////////////
   // Select line latch and strobe decode

   logic [4:0] live_sel;
   logic [4:0] eff_sel;
   logic [4:0] held_ff;
   logic [4:0] nxt_held;
   logic strobe;
   logic cs_act;
   logic iack_act;

   assign live_sel = {BUS.byte_high_enable_n, BUS.register_select, BUS.port_select_n};
   // In multiplexed mode transparent while the address strobe is high, holds while it is low; always transparent otherwise
   assign eff_sel = (MODE_MUX && !BUS.register_address_strobe) ? held_ff : live_sel;
   assign strobe = MODE_MUX ? !BUS.lower_data_strobe_n
                            : (!BUS.lower_data_strobe_n || !BUS.upper_data_strobe_n);
   assign cs_act = !eff_sel[0];
   assign iack_act = !BUS.interrupt_ack_n;

   always_comb begin
      nxt_held = held_ff;
      if (BUS.register_address_strobe) begin
         nxt_held = live_sel;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         held_ff <= 5'h1F;
      end else begin
         held_ff <= nxt_held;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt acknowledge pulse tracking

   logic iack_prev_ff;
   logic first_pulse_ff;
   logic nxt_first_pulse;
   logic vec_go;
   dev_state_e state_ff;

   always_comb begin
      nxt_first_pulse = first_pulse_ff;
      if (state_ff == D_IDLE && MODE_MUX && iack_prev_ff && !iack_act && !first_pulse_ff) begin
         nxt_first_pulse = 1'b1;
      end else if (vec_go) begin
         nxt_first_pulse = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         iack_prev_ff <= 1'b0;
         first_pulse_ff <= 1'b0;
      end else begin
         iack_prev_ff <= iack_act;
         first_pulse_ff <= nxt_first_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer

   logic rd_go;
   logic wr_go;
   logic release_seen;
   logic is_vec_ff;
   logic nxt_is_vec;
   dev_state_e nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic wben_ff;
   logic nxt_wben;
   logic wdir_ff;
   logic nxt_wdir;
   logic dout_oe_ff;
   logic nxt_dout_oe;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic [15:0] wdata_ff;
   logic [15:0] nxt_wdata;
   logic we_ff;
   logic nxt_we;
   logic rd_ff;
   logic nxt_rd;
   logic [2:0] addr_ff;
   logic [2:0] nxt_addr;
   logic bhe_ff;
   logic nxt_bhe;
   logic iack_done_ff;
   logic nxt_iack_done;

   // Second pulse in multiplexed mode, or acknowledge with read strobe otherwise
   assign vec_go = state_ff == D_IDLE && !REG_BUSY && iack_act && !cs_act &&
                   (MODE_MUX ? first_pulse_ff : (strobe && BUS.read_not_write));
   // Busy keeps the sequencer idle without acknowledging
   assign rd_go = (state_ff == D_IDLE && !REG_BUSY && cs_act && strobe &&
                   BUS.read_not_write && !iack_act) || vec_go;
   assign wr_go = state_ff == D_IDLE && !REG_BUSY && cs_act && strobe &&
                  !BUS.read_not_write && !iack_act;
   assign release_seen = is_vec_ff ? !iack_act : (!strobe || !cs_act);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_wben = wben_ff;
      nxt_wdir = wdir_ff;
      nxt_dout_oe = dout_oe_ff;
      nxt_rdata = rdata_ff;
      nxt_wdata = wdata_ff;
      nxt_we = 1'b0;
      nxt_rd = 1'b0;
      nxt_addr = addr_ff;
      nxt_bhe = bhe_ff;
      nxt_is_vec = is_vec_ff;
      nxt_iack_done = 1'b0;
      case (state_ff)
         D_IDLE: begin
            nxt_wdir = 1'b0;
            nxt_dout_oe = 1'b0;
            nxt_cnt = CNT_RST;
            if (rd_go) begin
               nxt_state = D_READ;
               nxt_is_vec = vec_go;
               nxt_rd = !vec_go;
               nxt_dout_oe = 1'b1;
               nxt_addr = eff_sel[3:1];
               nxt_bhe = eff_sel[4];
               nxt_iack_done = vec_go;
            end else if (wr_go) begin
               nxt_state = D_WRITE;
               nxt_is_vec = 1'b0;
               nxt_wdir = 1'b1;
               nxt_addr = eff_sel[3:1];
               nxt_bhe = eff_sel[4];
            end
         end
         D_READ: begin
            nxt_cnt = cnt_ff + 8'h01;
            // Register side answers for the address registered one edge earlier
            if (cnt_ff == 8'h00) begin
               nxt_rdata = is_vec_ff ? {{(16 - VEC_W){1'b0}}, IRQ_VECTOR} : REG_RDATA;
            end
            if (cnt_ff == 8'(RD_HOLD_CYC - 1)) begin
               nxt_state = D_ACK;
            end
         end
         D_WRITE: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == 8'(WR_BEN_EDGE - 1)) begin
               nxt_wben = 1'b1;
            end
            if (cnt_ff == 8'(WR_CAP_EDGE - 1)) begin
               // Upper lane is dropped on a narrow bus
               nxt_wdata = {BUS_8BIT ? 8'h00 : BUS.upper_addr_data_byte,
                            BUS.lower_addr_data_byte};
               nxt_we = 1'b1;
               nxt_wben = 1'b0;
               nxt_state = D_ACK;
            end
         end
         D_ACK: begin
            if (release_seen) begin
               nxt_state = D_DRVHI;
            end
         end
         D_DRVHI: begin
            if (BUS.ready_ack_out) begin
               nxt_state = D_DONE;
            end
         end
         D_DONE: begin
            nxt_dout_oe = 1'b0;
            nxt_state = D_IDLE;
         end
         default: begin
            nxt_state = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_ff <= D_IDLE;
         cnt_ff <= CNT_RST;
         wben_ff <= 1'b0;
         wdir_ff <= 1'b0;
         dout_oe_ff <= 1'b0;
         rdata_ff <= RDATA_RST;
         wdata_ff <= RDATA_RST;
         we_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 3'h0;
         bhe_ff <= 1'b1;
         is_vec_ff <= 1'b0;
         iack_done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wben_ff <= nxt_wben;
         wdir_ff <= nxt_wdir;
         dout_oe_ff <= nxt_dout_oe;
         rdata_ff <= nxt_rdata;
         wdata_ff <= nxt_wdata;
         we_ff <= nxt_we;
         rd_ff <= nxt_rd;
         addr_ff <= nxt_addr;
         bhe_ff <= nxt_bhe;
         is_vec_ff <= nxt_is_vec;
         iack_done_ff <= nxt_iack_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive

   // Read enable follows the request without waiting for an edge
   assign BUS.data_buffer_enable_n = !(rd_go || state_ff == D_READ || wben_ff);
   // Low toward the device through the whole write, high for reads
   assign BUS.data_buffer_direction = !(wr_go || wdir_ff);
   assign BUS.lo_dev_o = rdata_ff[7:0];
   assign BUS.lo_dev_oe = dout_oe_ff;
   assign BUS.hi_dev_o = rdata_ff[15:8];
   assign BUS.hi_dev_oe = dout_oe_ff && !BUS_8BIT;
   assign BUS.ready_ack_out_o = state_ff != D_ACK;
   // Released only after the line is seen high
   assign BUS.ready_ack_out_oe = state_ff == D_ACK || state_ff == D_DRVHI;

   assign REG_ADDR = addr_ff;
   assign REG_BYTE_HIGH_N = bhe_ff;
   assign REG_WDATA = wdata_ff;
   assign REG_WE = we_ff;
   assign REG_RD = rd_ff;
   assign IACK_DONE = iack_done_ff;

endmodule

// File: hdl/hdrp_pkg.sv
// Constants and types shared by both ends of the host register port
// Summary of operation
// - Write data captured fifth rising edge after sample
// - Write buffer enable asserted third edge after sample
// - Buffer enable drops on the same edge that ready acknowledge asserts
// - Host holds address, data, direction until acknowledge
// - Drive ready high, confirm high, then release
// - Address strobe latches select lines in multiplexed mode; high passes through
// - 8-bit reads leave upper byte lines undriven
// - 8-bit writes ignore upper byte lines
// - Host holds strobes after acknowledge for direction hold
// - Two acknowledge pulses fetch the interrupt vector in multiplexed mode; otherwise one acknowledge with the read strobe
// - No acknowledge during accesses, no select during acknowledge
// - Read starts on select, strobe, not busy; immediate enable
// - Write starts on select, strobe, not busy
package hdrp_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Edge numbers counted after the sample point
   localparam int unsigned WR_BEN_EDGE = 3;
   localparam int unsigned WR_CAP_EDGE = 5;
   localparam int unsigned RD_HOLD_CYC = 2;
   // Host side times, least values
   localparam int unsigned RAS_HIGH_NS = 40;
   localparam int unsigned RAS_SETUP_NS = 42;
   localparam int unsigned ACK_TO_RELEASE_NS = 1000;
   localparam int unsigned STROBE_GAP_NS = 100;
   localparam int unsigned IACK_LOW_NS = 150;
   localparam int unsigned RAS_HIGH_CYC = (RAS_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RAS_SETUP_CYC =
      (RAS_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ACK_HOLD_CYC =
      (ACK_TO_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned GAP_CYC = (STROBE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned IACK_LOW_CYC = (IACK_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Reset values
   localparam logic [15:0] RDATA_RST = 16'h0000;
   localparam logic [7:0] CNT_RST = 8'h00;

   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_READ = 3'b001,
      D_ACK = 3'b011,
      D_DRVHI = 3'b010,
      D_DONE = 3'b110,
      D_WRITE = 3'b101
   } dev_state_e;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ADDR = 3'b001,
      H_SETUP = 3'b011,
      H_STRB = 3'b010,
      H_HOLD = 3'b110,
      H_GAP = 3'b111,
      H_IACK1 = 3'b100,
      H_IGAP = 3'b101
   } host_state_e;
endpackage

// File: hdl/hdrp_if.sv
// Pin-level carrier between the host and the register port device
`timescale 1ns/1ps
interface hdrp_if;
   // Host driven
   logic port_select_n;
   logic interrupt_ack_n;
   logic read_not_write;
   logic [2:0] register_select;
   logic byte_high_enable_n;
   logic register_address_strobe;
   logic lower_data_strobe_n;
   logic upper_data_strobe_n;
   logic [7:0] lo_host_o;
   logic lo_host_oe;
   logic [7:0] hi_host_o;
   logic hi_host_oe;
   // Device driven
   logic [7:0] lo_dev_o;
   logic lo_dev_oe;
   logic [7:0] hi_dev_o;
   logic hi_dev_oe;
   logic ready_ack_out_o;
   logic ready_ack_out_oe;
   logic data_buffer_enable_n;
   logic data_buffer_direction;
   // Resolved wires, pulled up when nobody drives
   logic [7:0] lower_addr_data_byte;
   logic [7:0] upper_addr_data_byte;
   logic ready_ack_out;

   assign lower_addr_data_byte = lo_dev_oe ? lo_dev_o : (lo_host_oe ? lo_host_o : 8'hFF);
   assign upper_addr_data_byte = hi_dev_oe ? hi_dev_o : (hi_host_oe ? hi_host_o : 8'hFF);
   assign ready_ack_out = ready_ack_out_oe ? ready_ack_out_o : 1'b1;

   modport device (
      input port_select_n, interrupt_ack_n, read_not_write, register_select,
      input byte_high_enable_n, register_address_strobe, lower_data_strobe_n,
      input upper_data_strobe_n, lower_addr_data_byte, upper_addr_data_byte, ready_ack_out,
      output lo_dev_o, lo_dev_oe, hi_dev_o, hi_dev_oe, ready_ack_out_o, ready_ack_out_oe,
      output data_buffer_enable_n, data_buffer_direction
   );
   modport host (
      output port_select_n, interrupt_ack_n, read_not_write, register_select,
      output byte_high_enable_n, register_address_strobe, lower_data_strobe_n,
      output upper_data_strobe_n, lo_host_o, lo_host_oe, hi_host_o, hi_host_oe,
      input lower_addr_data_byte, upper_addr_data_byte, ready_ack_out,
      input data_buffer_enable_n, data_buffer_direction
   );
endinterface

// File: hdl/hdrp_host.sv
// Host end: drives register accesses and vector fetches on the port
`timescale 1ns/1ps
module hdrp_host
   import hdrp_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Device pins
   hdrp_if.host BUS,
   // Straps
   input wire logic MODE_MUX,
   input wire logic BUS_8BIT,
   // Command side
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_WRITE,
   input wire logic CMD_VECTOR,
   input wire logic [2:0] CMD_ADDR,
   input wire logic CMD_BYTE_HIGH_N,
   input wire logic [15:0] CMD_WDATA,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA
);

   host_state_e state_ff;
   host_state_e nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic cs_n_ff, nxt_cs_n;
   logic iack_n_ff, nxt_iack_n;
   logic rnw_ff, nxt_rnw;
   logic [2:0] rs_ff, nxt_rs;
   logic bhe_ff, nxt_bhe;
   logic ras_ff, nxt_ras;
   logic strb_ff, nxt_strb;
   logic vec_ff, nxt_vec;
   logic [15:0] dout_ff, nxt_dout;
   logic doe_ff, nxt_doe;
   logic [15:0] rdata_ff, nxt_rdata;
   logic rsp_ff, nxt_rsp;

   assign CMD_READY = state_ff == H_IDLE;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 8'h01;
      nxt_cs_n = cs_n_ff;
      nxt_iack_n = iack_n_ff;
      nxt_rnw = rnw_ff;
      nxt_rs = rs_ff;
      nxt_bhe = bhe_ff;
      nxt_ras = ras_ff;
      nxt_strb = strb_ff;
      nxt_vec = vec_ff;
      nxt_dout = dout_ff;
      nxt_doe = doe_ff;
      nxt_rdata = rdata_ff;
      nxt_rsp = 1'b0;
      case (state_ff)
         H_IDLE: begin
            nxt_cnt = CNT_RST;
            if (CMD_VALID) begin
               nxt_vec = CMD_VECTOR;
               nxt_rnw = CMD_VECTOR || !CMD_WRITE;
               nxt_rs = CMD_ADDR;
               nxt_bhe = CMD_BYTE_HIGH_N;
               nxt_dout = CMD_WDATA;
               if (CMD_VECTOR && MODE_MUX) begin
                  nxt_iack_n = 1'b0;
                  // Open the select latch so the inactive select replaces the last access
                  nxt_ras = 1'b1;
                  nxt_state = H_IACK1;
               end else begin
                  // Select only for register accesses
                  nxt_cs_n = CMD_VECTOR;
                  nxt_ras = 1'b1;
                  nxt_state = H_ADDR;
               end
            end
         end
         H_ADDR: begin
            if (cnt_ff == 8'(RAS_HIGH_CYC - 1)) begin
               nxt_ras = 1'b0;
               nxt_cnt = CNT_RST;
               nxt_state = H_SETUP;
            end
         end
         H_SETUP: begin
            if (cnt_ff == 8'(RAS_SETUP_CYC - 1)) begin
               nxt_strb = 1'b1;
               nxt_iack_n = !vec_ff;
               nxt_doe = !rnw_ff;
               nxt_state = H_STRB;
            end
         end
         H_IACK1: begin
            if (cnt_ff == 8'(IACK_LOW_CYC - 1)) begin
               nxt_iack_n = 1'b1;
               nxt_cnt = CNT_RST;
               nxt_state = H_IGAP;
            end
         end
         H_IGAP: begin
            if (cnt_ff == 8'(GAP_CYC - 1)) begin
               nxt_iack_n = 1'b0;
               nxt_state = H_STRB;
            end
         end
         H_STRB: begin
            nxt_cnt = CNT_RST;
            if (!BUS.ready_ack_out) begin
               nxt_rdata = {BUS.upper_addr_data_byte, BUS.lower_addr_data_byte};
               // Write data may go once acknowledged
               nxt_doe = 1'b0;
               nxt_state = H_HOLD;
            end
         end
         H_HOLD: begin
            // Strobes stay low so the device can keep direction valid
            if (cnt_ff == 8'(ACK_HOLD_CYC - 1)) begin
               nxt_strb = 1'b0;
               nxt_iack_n = 1'b1;
               nxt_cs_n = 1'b1;
               nxt_cnt = CNT_RST;
               nxt_state = H_GAP;
            end
         end
         H_GAP: begin
            if (cnt_ff >= 8'(GAP_CYC - 1) && BUS.ready_ack_out) begin
               nxt_rsp = 1'b1;
               nxt_state = H_IDLE;
            end
         end
         default: begin
            nxt_state = H_IDLE;
         end
      endcase
      if (BUS_8BIT) begin
         nxt_rdata[15:8] = 8'h00;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_ff <= H_IDLE;
         cnt_ff <= CNT_RST;
         cs_n_ff <= 1'b1;
         iack_n_ff <= 1'b1;
         rnw_ff <= 1'b1;
         rs_ff <= 3'h0;
         bhe_ff <= 1'b1;
         ras_ff <= 1'b0;
         strb_ff <= 1'b0;
         vec_ff <= 1'b0;
         dout_ff <= RDATA_RST;
         doe_ff <= 1'b0;
         rdata_ff <= RDATA_RST;
         rsp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         cs_n_ff <= nxt_cs_n;
         iack_n_ff <= nxt_iack_n;
         rnw_ff <= nxt_rnw;
         rs_ff <= nxt_rs;
         bhe_ff <= nxt_bhe;
         ras_ff <= nxt_ras;
         strb_ff <= nxt_strb;
         vec_ff <= nxt_vec;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         rdata_ff <= nxt_rdata;
         rsp_ff <= nxt_rsp;
      end
   end

   assign BUS.port_select_n = cs_n_ff;
   assign BUS.interrupt_ack_n = iack_n_ff;
   assign BUS.read_not_write = rnw_ff;
   assign BUS.register_select = rs_ff;
   assign BUS.byte_high_enable_n = bhe_ff;
   assign BUS.register_address_strobe = ras_ff;
   assign BUS.lower_data_strobe_n = !strb_ff;
   assign BUS.upper_data_strobe_n = !(strb_ff && !MODE_MUX && !bhe_ff);
   assign BUS.lo_host_o = dout_ff[7:0];
   assign BUS.lo_host_oe = doe_ff;
   assign BUS.hi_host_o = dout_ff[15:8];
   assign BUS.hi_host_oe = doe_ff && !BUS_8BIT;
   assign RSP_VALID = rsp_ff;
   assign RSP_RDATA = rdata_ff;

endmodule

// File: verif/hdrp_properties.sv
// Pin-level checks on the link between the host end and the device end
`timescale 1ns/1ps
module hdrp_properties
   import hdrp_pkg::*;
(
   // Clock, reset and strap
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic BUS_8BIT,
   // Host driven pins
   input wire logic port_select_n,
   input wire logic interrupt_ack_n,
   input wire logic read_not_write,
   input wire logic [2:0] register_select,
   input wire logic lower_data_strobe_n,
   // Device driven pins
   input wire logic hi_dev_oe,
   input wire logic ready_ack_out_o,
   input wire logic ready_ack_out_oe,
   input wire logic ready_ack_out,
   input wire logic data_buffer_enable_n,
   input wire logic data_buffer_direction
);
   logic [8:0] hold_cnt_ff;
   logic [8:0] nxt_hold_cnt;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles the strobe has stayed low since the acknowledge came
   always_comb begin
      nxt_hold_cnt = hold_cnt_ff;
      if (lower_data_strobe_n) begin
         nxt_hold_cnt = 9'h000;
      end else if ((!ready_ack_out || hold_cnt_ff != 9'h000) && hold_cnt_ff != 9'h1FF) begin
         nxt_hold_cnt = hold_cnt_ff + 9'h001;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         hold_cnt_ff <= 9'h000;
      end else begin
         hold_cnt_ff <= nxt_hold_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_WR_BEN_THIRD_EDGE: assert property (
      $fell(data_buffer_direction) |-> data_buffer_enable_n[*4] ##1 !data_buffer_enable_n)
      else $error("write buffer enable not on third edge after sample");
   AST_WR_CAPTURE_FIFTH_EDGE: assert property (
      $fell(data_buffer_enable_n) && !data_buffer_direction |=> !data_buffer_enable_n ##1
      (data_buffer_enable_n && ready_ack_out_oe && !ready_ack_out_o))
      else $error("write not completed on fifth edge after sample");
   AST_BEN_OFF_BEFORE_ACK: assert property (
      !ready_ack_out |-> data_buffer_enable_n)
      else $error("buffer enable active while acknowledge low");
   AST_ACK_HIGH_BEFORE_RELEASE: assert property (
      $fell(ready_ack_out_oe) |-> $past(ready_ack_out_o) && $past(ready_ack_out))
      else $error("acknowledge released without being driven high");
   AST_UPPER_LANE_UNDRIVEN_8BIT: assert property (
      BUS_8BIT |-> !hi_dev_oe)
      else $error("upper byte lane driven in 8-bit mode");
   AST_DIR_FOLLOWS_ACCESS: assert property (
      !data_buffer_enable_n && !port_select_n |-> data_buffer_direction == read_not_write)
      else $error("buffer direction does not match access kind");
   AST_HOST_HOLDS_ADDRESS: assert property (
      !lower_data_strobe_n && $past(!lower_data_strobe_n) && $past(ready_ack_out) &&
      !port_select_n |-> $stable(register_select) && $stable(read_not_write))
      else $error("host changed address or direction before acknowledge");
   AST_HOST_HOLDS_STROBE: assert property (
      $rose(lower_data_strobe_n) && hold_cnt_ff != 9'h000 |-> hold_cnt_ff >= 9'(ACK_HOLD_CYC))
      else $error("host released strobe too soon after acknowledge");
   AST_IACK_SELECT_EXCLUSIVE: assert property (
      !interrupt_ack_n |-> port_select_n)
      else $error("select and interrupt acknowledge low together");
endmodule

// File: verif/host_direct_register_port_test.sv
// Self-checking bench joining the host end and the device end of the register port
`timescale 1ns/1ps
module host_direct_register_port_test;
   logic sys_clk;
   logic rst;
   logic mode_mux;
   logic bus_8bit;
   logic cmd_valid;
   logic cmd_ready;
   logic cmd_write;
   logic cmd_vector;
   logic [2:0] cmd_addr;
   logic cmd_byte_high_n;
   logic [15:0] cmd_wdata;
   logic rsp_valid;
   logic [15:0] rsp_rdata;
   logic [2:0] reg_addr;
   logic reg_byte_high_n;
   logic [15:0] reg_wdata;
   logic reg_we;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic reg_busy;
   logic [7:0] irq_vector;
   logic iack_done;
   logic [15:0] mem [0:7];
   logic [15:0] exp_mem [0:7];
   int err_count;
   int total_checks;
   int seed;
   int we_seen;
   int iack_seen;

   hdrp_if bus_if ();

   hdrp_device #(.VEC_W(8)) hdrp_device_inst (.SYS_CLK(sys_clk), .RST(rst), .BUS(bus_if.device),
      .MODE_MUX(mode_mux), .BUS_8BIT(bus_8bit), .REG_ADDR(reg_addr),
      .REG_BYTE_HIGH_N(reg_byte_high_n), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .REG_BUSY(reg_busy), .IRQ_VECTOR(irq_vector),
      .IACK_DONE(iack_done));

   hdrp_host hdrp_host_inst (.SYS_CLK(sys_clk), .RST(rst), .BUS(bus_if.host),
      .MODE_MUX(mode_mux), .BUS_8BIT(bus_8bit), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
      .CMD_WRITE(cmd_write), .CMD_VECTOR(cmd_vector), .CMD_ADDR(cmd_addr),
      .CMD_BYTE_HIGH_N(cmd_byte_high_n), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata));

   hdrp_properties hdrp_properties_inst (.SYS_CLK(sys_clk), .RST(rst), .BUS_8BIT(bus_8bit),
      .port_select_n(bus_if.port_select_n), .interrupt_ack_n(bus_if.interrupt_ack_n),
      .read_not_write(bus_if.read_not_write), .register_select(bus_if.register_select),
      .lower_data_strobe_n(bus_if.lower_data_strobe_n), .hi_dev_oe(bus_if.hi_dev_oe),
      .ready_ack_out_o(bus_if.ready_ack_out_o), .ready_ack_out_oe(bus_if.ready_ack_out_oe),
      .ready_ack_out(bus_if.ready_ack_out), .data_buffer_enable_n(bus_if.data_buffer_enable_n),
      .data_buffer_direction(bus_if.data_buffer_direction));

   ////////////////////////////////////////////////////////////////////////////////
   // Register file standing behind the device
   assign reg_rdata = mem[reg_addr];

   always @(posedge sys_clk) begin
      if (reg_we === 1'b1) begin
         mem[reg_addr] <= reg_wdata;
         we_seen++;
      end
      if (iack_done === 1'b1) begin
         iack_seen++;
      end
      if (reg_busy === 1'b1 && rst === 1'b0) begin
         check({13'h0000, reg_we, reg_rd, ~bus_if.data_buffer_enable_n}, 16'h0000);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lane_mask(input logic b8);
      return b8 ? 16'h00FF : 16'hFFFF;
   endfunction

   function automatic logic [15:0] stored_value(input logic b8, input logic [15:0] d);
      return b8 ? {8'h00, d[7:0]} : d;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One host command, held until taken, with the register side busy for a while
   task automatic do_op(input logic wr, input logic vec, input logic [2:0] a,
      input logic [15:0] d, input int busy_cyc);
      int n;
      int we0;
      int iack0;
      @(negedge sys_clk);
      we0 = we_seen;
      iack0 = iack_seen;
      irq_vector = 8'($random(seed));
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_vector = vec;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_byte_high_n = 1'($random(seed));
      n = 0;
      while (cmd_ready !== 1'b1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      reg_busy = (busy_cyc > 0);
      repeat (busy_cyc) @(negedge sys_clk);
      reg_busy = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      check({15'h0000, rsp_valid}, 16'h0001);
      if (!vec) begin
         check({12'h000, reg_byte_high_n, reg_addr}, {12'h000, cmd_byte_high_n, a});
      end
      if (vec) begin
         check(rsp_rdata & lane_mask(bus_8bit), {8'h00, irq_vector} & lane_mask(bus_8bit));
         check(16'(iack_seen - iack0), 16'h0001);
      end else if (wr) begin
         exp_mem[a] = stored_value(bus_8bit, d);
         check(16'(we_seen - we0), 16'h0001);
         check(mem[a], exp_mem[a]);
      end else begin
         check(rsp_rdata & lane_mask(bus_8bit), exp_mem[a] & lane_mask(bus_8bit));
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      check(16'h0000, 16'h0001);
      print_verdict();
   end

   initial begin
      seed = 7;
      err_count = 0;
      total_checks = 0;
      we_seen = 0;
      iack_seen = 0;
      rst = 1'b1;
      mode_mux = 1'b0;
      bus_8bit = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_vector = 1'b0;
      cmd_addr = 3'h0;
      cmd_byte_high_n = 1'b1;
      cmd_wdata = 16'h0000;
      reg_busy = 1'b0;
      irq_vector = 8'h00;
      for (int i = 0; i < 8; i++) begin
         mem[i] = 16'h0000;
         exp_mem[i] = 16'h0000;
      end
      for (int mode = 0; mode < 4; mode++) begin
         mode_mux = mode[0];
         bus_8bit = mode[1];
         rst = 1'b1;
         repeat (16) @(negedge sys_clk);
         rst = 1'b0;
         do_op(1'b1, 1'b0, 3'h0, 16'hFFFF, 0);
         do_op(1'b1, 1'b0, 3'h7, 16'h0000, 0);
         for (int i = 0; i < 8; i++) begin
            do_op(1'b0, 1'b0, 3'(i), 16'h0000, 0);
         end
         for (int i = 0; i < 12; i++) begin
            do_op(1'($random(seed)), 1'b0, 3'($random(seed)), 16'($random(seed)), (i % 3) * 15);
         end
         do_op(1'b0, 1'b1, 3'h0, 16'h0000, 0);
         do_op(1'b0, 1'b1, 3'h0, 16'h0000, 20);
      end
      print_verdict();
   end
endmodule
